/* File: io_ctrl_pkg.sv */
`default_nettype none
package io_ctrl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         T_MIN_NS      = 185;
  localparam int         CLK_PERIOD_NS = 20;
  localparam logic [3:0] T_MIN_CYC     = 4'((T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int         WORD_W     = 8;
  localparam int         FIFO_DEPTH = 16;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] CC_ZERO    = 2'h0;

  // Service kinds, coded as {data_or_order_line, in_out_line}
  typedef enum logic [1:0] {
    SVC_DATA_IN   = 2'b00,
    SVC_DATA_OUT  = 2'b01,
    SVC_ORDER_IN  = 2'b10,
    SVC_ORDER_OUT = 2'b11
  } svc_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CALL    = 3'b001,
    ST_LOAD    = 3'b010,
    ST_SETUP   = 3'b011,
    ST_STROBE  = 3'b100,
    ST_RELEASE = 3'b101
  } conn_state_t;

  typedef struct packed {
    logic start_op_indicator;
    logic halt_op_indicator;
    logic test_op_indicator;
    logic test_device_indicator;
    logic ack_interrupt_indicator;
    logic ack_service_indicator;
  } fn_ind_t;

  // Cable lines driven by the processor towards this controller
  typedef struct packed {
    fn_ind_t    ind;
    logic       function_strobe;
    logic       strobe_ack;
    logic       end_service;
    logic       end_data;
    logic [7:0] data;
  } link_in_t;

  localparam link_in_t LINK_IDLE = '0;

endpackage
`default_nettype wire

/* File: peripheral_port.sv */
// Contract
// - Raise service call to request service
// - Hold service call until service indicator
// - Answer strobe with acknowledge or available
// - Interrupt ack returns address, codes, status
// - Service ack answered by calling controller
// - Present condition codes until strobe drops
// - Connect at strobe fall, raise request
// - Keep request type until first acknowledge
// - Response lines carry status or address
// - Keep response lines until strobe drops
// - Keep strobing until acknowledge with end
// - Status on data lines until strobe drops
`timescale 1ns/100ps
`default_nettype none

module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module peripheral_port
  import io_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire link_in_t   link_i,
  output logic            service_call,
  output logic            function_acknowledge,
  output logic            available_response,
  output logic            data_or_order_line,
  output logic            in_out_line,
  output logic      [7:0] function_response_lines,
  output logic            request_strobe,
  output logic            end_data_o,
  output logic            end_data_oe,
  output logic      [7:0] data_o,
  output logic            data_oe,
  input  wire logic [7:0] my_addr,
  input  wire logic [7:0] dev_status,
  input  wire logic [1:0] cond_code,
  input  wire logic       irq_pending,
  input  wire logic       svc_req,
  input  wire svc_kind_t  svc_kind,
  output logic            svc_busy,
  input  wire logic [7:0] op_status,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            order_valid,
  output logic      [7:0] order_byte,
  output logic            term_valid,
  output logic      [7:0] term_byte
);

  // ---------------------------------------------------------------
  // Cable input synchroniser
  // ---------------------------------------------------------------
  link_in_t    meta_r;
  link_in_t    sync_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= LINK_IDLE;
      sync_r <= LINK_IDLE;
    end else begin
      meta_r <= link_i;
      sync_r <= meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Function strobe responder
  // ---------------------------------------------------------------
  conn_state_t state_r;
  logic        fsl_r;
  logic        avo_r;
  logic [7:0]  fr_r;
  logic [1:0]  cc_r;
  logic        st_drive_r;
  logic [7:0]  st_byte_r;
  logic        cpu_op;
  logic        calling;

  assign cpu_op  = sync_r.ind.start_op_indicator | sync_r.ind.halt_op_indicator |
                   sync_r.ind.test_op_indicator | sync_r.ind.test_device_indicator;
  assign calling = (state_r == ST_CALL);

  always_ff @(posedge clk) begin
    if (srst) begin
      fsl_r      <= 1'b0;
      avo_r      <= 1'b0;
      fr_r       <= BYTE_ZERO;
      cc_r       <= CC_ZERO;
      st_drive_r <= 1'b0;
      st_byte_r  <= BYTE_ZERO;
    end else if (!sync_r.function_strobe) begin
      fsl_r      <= 1'b0;
      avo_r      <= 1'b0;
      st_drive_r <= 1'b0;
    end else if (!fsl_r && !avo_r) begin
      if (sync_r.ind.ack_service_indicator) begin
        fsl_r <= calling;
        avo_r <= !calling;
        fr_r  <= my_addr;
        cc_r  <= CC_ZERO;
      end else if (sync_r.ind.ack_interrupt_indicator) begin
        fsl_r      <= irq_pending;
        avo_r      <= !irq_pending;
        fr_r       <= my_addr;
        cc_r       <= cond_code;
        st_drive_r <= irq_pending;
        st_byte_r  <= dev_status;
      end else if (cpu_op && (sync_r.data == my_addr)) begin
        fsl_r <= 1'b1;
        fr_r  <= dev_status;
        cc_r  <= cond_code;
      end
    end
  end

  // ---------------------------------------------------------------
  // Service sequencer
  // ---------------------------------------------------------------
  svc_kind_t   kind_r;
  logic        asc_seen_r;
  logic        granted_r;
  logic [3:0]  cnt_r;
  logic [7:0]  data_r;
  logic        ed_r;
  logic        term_r;
  logic        done_r;
  logic        first_ack_r;
  logic        rx_space;
  logic        can_go;
  logic        conn;
  logic        output_kind;
  logic        ended;

  assign output_kind = kind_r[0];
  assign ended       = ed_r || sync_r.end_data;
  assign conn        = (state_r == ST_LOAD) || (state_r == ST_SETUP) ||
                       (state_r == ST_STROBE) || (state_r == ST_RELEASE);

  always_comb begin
    can_go = 1'b1;
    if (!term_r) begin
      case (kind_r)
        SVC_DATA_IN:  can_go = tx_valid;
        SVC_DATA_OUT: can_go = rx_space;
        default:      can_go = 1'b1;
      endcase
    end
  end

  assign tx_ready = (state_r == ST_LOAD) && can_go && !term_r && (kind_r == SVC_DATA_IN);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      kind_r      <= SVC_DATA_IN;
      asc_seen_r  <= 1'b0;
      granted_r   <= 1'b0;
      cnt_r       <= 4'h0;
      data_r      <= BYTE_ZERO;
      ed_r        <= 1'b0;
      term_r      <= 1'b0;
      done_r      <= 1'b0;
      first_ack_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          asc_seen_r  <= 1'b0;
          granted_r   <= 1'b0;
          term_r      <= 1'b0;
          done_r      <= 1'b0;
          first_ack_r <= 1'b0;
          ed_r        <= 1'b0;
          if (svc_req) begin
            kind_r  <= svc_kind;
            state_r <= ST_CALL;
          end
        end
        ST_CALL: begin
          if (sync_r.ind.ack_service_indicator) begin
            asc_seen_r <= 1'b1;
          end
          if (fsl_r && sync_r.ind.ack_service_indicator) begin
            granted_r <= 1'b1;
          end
          if (granted_r && !sync_r.function_strobe) begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (can_go) begin
            cnt_r   <= T_MIN_CYC;
            ed_r    <= 1'b0;
            state_r <= ST_SETUP;
            if (!term_r) begin
              case (kind_r)
                SVC_ORDER_IN: begin
                  data_r <= op_status;
                  ed_r   <= 1'b1;
                end
                SVC_ORDER_OUT: ed_r <= 1'b1;
                SVC_DATA_IN: begin
                  data_r <= tx_data;
                  ed_r   <= tx_last;
                end
                default: ed_r <= 1'b0;
              endcase
            end
          end
        end
        ST_SETUP: begin
          if (cnt_r == 4'h0) begin
            state_r <= ST_STROBE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_STROBE: begin
          if (sync_r.strobe_ack) begin
            first_ack_r <= 1'b1;
            state_r     <= ST_RELEASE;
            if (sync_r.end_service) begin
              done_r <= 1'b1;
            end else if (ended) begin
              term_r <= 1'b1;
            end
          end
        end
        ST_RELEASE: begin
          if (!sync_r.strobe_ack) begin
            state_r <= done_r ? ST_IDLE : ST_LOAD;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Captured bytes from the processor
  // ---------------------------------------------------------------
  logic rx_push;
  logic ack_edge;

  assign ack_edge = (state_r == ST_STROBE) && sync_r.strobe_ack;
  assign rx_push  = ack_edge && !sync_r.end_service && !term_r && (kind_r == SVC_DATA_OUT);

  always_ff @(posedge clk) begin
    if (srst) begin
      order_valid <= 1'b0;
      order_byte  <= BYTE_ZERO;
      term_valid  <= 1'b0;
      term_byte   <= BYTE_ZERO;
    end else begin
      order_valid <= ack_edge && !term_r && !sync_r.end_service && (kind_r == SVC_ORDER_OUT);
      term_valid  <= ack_edge && sync_r.end_service;
      if (ack_edge && !term_r && (kind_r == SVC_ORDER_OUT)) begin
        order_byte <= sync_r.data;
      end
      if (ack_edge && sync_r.end_service) begin
        term_byte <= sync_r.data;
      end
    end
  end

  fifo_buf #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) rx_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (rx_push),
    .in_ready  (rx_space),
    .in_data   (sync_r.data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ---------------------------------------------------------------
  // Cable outputs
  // ---------------------------------------------------------------
  logic conn_drive;

  assign conn_drive = ((state_r == ST_SETUP) || (state_r == ST_STROBE)) &&
                      !output_kind && !term_r;

  assign service_call            = calling && !asc_seen_r;
  assign function_acknowledge    = fsl_r;
  assign available_response      = avo_r;
  assign function_response_lines = fr_r;
  // codes during response, kind when connected
  assign data_or_order_line      = (fsl_r || avo_r) ? cc_r[1] : (conn & kind_r[1]);
  assign in_out_line             = (fsl_r || avo_r) ? cc_r[0] : (conn & kind_r[0]);
  assign request_strobe          = (state_r == ST_STROBE);
  assign end_data_o              = ed_r;
  assign end_data_oe             = (state_r == ST_SETUP || state_r == ST_STROBE) && ed_r;
  // status on data lines for interrupt ack
  assign data_o                  = st_drive_r ? st_byte_r : data_r;
  assign data_oe                 = st_drive_r || conn_drive;
  assign svc_busy                = (state_r != ST_IDLE);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_call_hold: assert property (
    $fell(service_call) |-> asc_seen_r || !calling)
    else $error("service call dropped before indicator");

  a_resp_drop: assert property (
    (!sync_r.function_strobe && $past(!sync_r.function_strobe)) |->
      !function_acknowledge && !available_response)
    else $error("response held after strobe fell");

  a_resp_excl: assert property (
    !(function_acknowledge && available_response))
    else $error("acknowledge and available together");

  a_cc_stable: assert property (
    (function_acknowledge && $past(function_acknowledge)) |->
      $stable({data_or_order_line, in_out_line}))
    else $error("condition codes changed during strobe");

  a_fr_stable: assert property (
    (function_acknowledge && $past(function_acknowledge)) |->
      $stable(function_response_lines))
    else $error("response lines changed during strobe");

  a_aio_status: assert property (
    (function_acknowledge && sync_r.ind.ack_interrupt_indicator && $past(function_acknowledge))
      |-> data_oe && (data_o == st_byte_r))
    else $error("status not driven on interrupt ack");

  a_type_hold: assert property (
    (conn && $past(conn) && !first_ack_r && !function_acknowledge && !available_response)
      |-> $stable({data_or_order_line, in_out_line}))
    else $error("request type changed before first ack");

  a_loop_drop: assert property (
    (request_strobe && sync_r.strobe_ack) |=> !request_strobe ##1 !request_strobe)
    else $error("request strobe kept after ack");

  a_end_cause: assert property (
    $rose(done_r) |-> $past(sync_r.strobe_ack && sync_r.end_service && request_strobe))
    else $error("service ended without end service");

  a_input_drive: assert property (
    (request_strobe && !kind_r[0] && !term_r) |-> data_oe && (data_o == data_r))
    else $error("input service not driving data");

endmodule
`default_nettype wire

/* File: io_proc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module io_proc_model
  import io_ctrl_pkg::*;
#(
  parameter logic [7:0] TERM_V = 8'hC3
) (
  input  wire logic       clk,
  input  wire logic       service_call,
  input  wire logic       function_acknowledge,
  input  wire logic       available_response,
  input  wire logic       data_or_order_line,
  input  wire logic       in_out_line,
  input  wire logic [7:0] function_response_lines,
  input  wire logic       request_strobe,
  input  wire logic       end_data_o,
  input  wire logic       end_data_oe,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe,
  output wire link_in_t   link_o
);
  fn_ind_t    ind_r, cpu_ind;
  logic       fs_r, rsa_r, es_r, ed_r, drv_r, cpu_go, fsl_q, avo_q, fin, term;
  logic [7:0] dat_r, cpu_addr, fr_q, st_q;
  logic [1:0] cc_q, kind_q;
  logic [7:0] out_q[$], rx_q[$];
  int         n_rs;

  // ---------------------------------------------------------------
  // Cable levels
  // ---------------------------------------------------------------
  // Released data lines show the inverse of the last value
  assign link_o = {ind_r, fs_r, rsa_r, es_r, end_data_oe ? end_data_o : ed_r,
                   data_oe ? data_o : (drv_r ? dat_r : ~dat_r)};

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task fn_op(input fn_ind_t ind, input logic [7:0] addr);
    // indicator and address lead the strobe
    ind_r = ind;
    dat_r = addr;
    drv_r = ~ind.ack_interrupt_indicator & ~ind.ack_service_indicator;
    tick(T_MIN_CYC);
    fs_r = 1'b1;
    for (int i = 0; i < 20 && !(function_acknowledge || available_response); i++) tick(1);
    tick(T_MIN_CYC);
    drv_r = 1'b0;
    fsl_q = function_acknowledge;
    avo_q = available_response;
    fr_q = function_response_lines;
    cc_q = {data_or_order_line, in_out_line};
    st_q = link_o.data;
    fs_r = 1'b0;
    for (int i = 0; i < 20 && (function_acknowledge || available_response); i++) tick(1);
    tick(T_MIN_CYC);
    ind_r = '0;
  endtask

  task serve();
    fn_op(fn_ind_t'(6'h01), 8'h00);
    n_rs = 0;
    fin = 1'b0;
    term = 1'b0;
    for (int g = 0; g < 3000 && fsl_q && !fin; g++) begin
      if (request_strobe) begin
        tick(T_MIN_CYC);
        // kind sampled during the first strobe
        if (n_rs == 0) kind_q = {data_or_order_line, in_out_line};
        if (term) begin
          dat_r = TERM_V;
          drv_r = 1'b1;
          es_r = 1'b1;
          fin = 1'b1;
        // output byte driven, input byte sampled
        end else if (kind_q[0]) begin
          dat_r = out_q.pop_front();
          drv_r = 1'b1;
          ed_r = (out_q.size() == 0) && !kind_q[1];
        end else begin
          rx_q.push_back(link_o.data);
        end
        tick(T_MIN_CYC);
        rsa_r = 1'b1;
        term = link_o.end_data;
        n_rs++;
        for (int i = 0; i < 40 && request_strobe; i++) tick(1);
        rsa_r = 1'b0;
        ed_r = 1'b0;
        tick(15);
        drv_r = 1'b0;
        es_r = 1'b0;
      end else begin
        tick(1);
      end
    end
  endtask

  initial begin
    ind_r = '0;
    {fs_r, rsa_r, es_r, ed_r, drv_r, cpu_go, fsl_q, avo_q} = 8'h00;
    dat_r = 8'h00;
    n_rs = 0;
    forever begin
      tick(1);
      // CPU request before a standing call
      if (cpu_go) begin
        fn_op(cpu_ind, cpu_addr);
        cpu_go = 1'b0;
      end else if (service_call) begin
        serve();
      end
    end
  end
endmodule
`default_nettype wire

/* File: io_processor_controller_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module io_processor_controller_port_tb_top
  import io_ctrl_pkg::*;
;
  localparam logic [7:0] TERM_V = 8'hC3;
  logic       clk, srst, svc_req, irq_pending, tx_valid, tx_last, rx_ready;
  link_in_t   link;
  svc_kind_t  svc_kind;
  logic [7:0] my_addr, dev_status, op_status, tx_data, term_got, ord_got;
  logic [1:0] cond_code;
  logic       service_call, function_acknowledge, available_response, data_or_order_line;
  logic       in_out_line, request_strobe, end_data_o, end_data_oe, data_oe, svc_busy;
  logic       tx_ready, rx_valid, order_valid, term_valid;
  logic [7:0] function_response_lines, data_o, rx_data, order_byte, term_byte;
  logic [7:0] rx_got[$], tx_q[$];
  int         n_mismatch = 0;
  int         samples_checked = 0;

  // ---------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------
  peripheral_port dut_u (.clk, .srst, .link_i(link), .service_call, .function_acknowledge,
    .available_response, .data_or_order_line, .in_out_line, .function_response_lines,
    .request_strobe, .end_data_o, .end_data_oe, .data_o, .data_oe, .my_addr, .dev_status,
    .cond_code, .irq_pending, .svc_req, .svc_kind, .svc_busy, .op_status, .tx_valid,
    .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data, .order_valid,
    .order_byte, .term_valid, .term_byte);

  io_proc_model #(.TERM_V(TERM_V)) proc_u (.clk, .service_call, .function_acknowledge,
    .available_response, .data_or_order_line, .in_out_line, .function_response_lines,
    .request_strobe, .end_data_o, .end_data_oe, .data_o, .data_oe, .link_o(link));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Data-in source and capture of the user side
  always @(posedge clk) begin
    if (rx_valid && rx_ready) rx_got.push_back(rx_data);
    if (term_valid) term_got = term_byte;
    if (order_valid) ord_got = order_byte;
    if (tx_valid && tx_ready) void'(tx_q.pop_front());
    #1;
    tx_valid = tx_q.size() > 0;
    tx_data = (tx_q.size() > 0) ? tx_q[0] : 8'h00;
    tx_last = tx_q.size() == 1;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task cpu_op(input fn_ind_t ind, input logic [7:0] a);
    int c;
    c = 0;
    proc_u.cpu_ind = ind;
    proc_u.cpu_addr = a;
    proc_u.cpu_go = 1'b1;
    while (proc_u.cpu_go && c < 500) begin
      tick(1);
      c++;
    end
    if (c >= 500) n_mismatch++;
    tick(5);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_cpu_ops();
    for (int k = 0; k < 4; k++) begin
      cpu_op(fn_ind_t'(6'h20 >> k), my_addr);
      check(16'(proc_u.fsl_q), 16'h0001);
      check(16'(proc_u.fr_q), 16'(dev_status));
      check(16'(proc_u.cc_q), 16'(cond_code));
    end
    cpu_op(fn_ind_t'(6'h20), my_addr ^ 8'h01);
    check(16'({proc_u.fsl_q, proc_u.avo_q}), 16'h0000);
  endtask

  task t_aio();
    irq_pending = 1'b1;
    cpu_op(fn_ind_t'(6'h02), 8'h00);
    check(16'(proc_u.fsl_q), 16'h0001);
    check(16'(proc_u.fr_q), 16'(my_addr));
    check(16'(proc_u.st_q), 16'(dev_status));
    check(16'(proc_u.cc_q), 16'(cond_code));
    irq_pending = 1'b0;
    cpu_op(fn_ind_t'(6'h02), 8'h00);
    check(16'(proc_u.avo_q), 16'h0001);
    cpu_op(fn_ind_t'(6'h01), 8'h00);
    check(16'(proc_u.avo_q), 16'h0001);
  endtask

  task t_svc(input svc_kind_t k, input int n, input logic stall);
    int c;
    c = 0;
    proc_u.out_q.delete();
    proc_u.rx_q.delete();
    rx_got.delete();
    term_got = 8'h00;
    ord_got = 8'h00;
    for (int i = 0; i < n; i++) begin
      proc_u.out_q.push_back(8'h40 + 8'(i));
      if (k == SVC_DATA_IN) tx_q.push_back(8'h80 + 8'(i));
    end
    rx_ready = !stall;
    svc_kind = k;
    svc_req = 1'b1;
    tick(1);
    svc_req = 1'b0;
    if (stall) begin
      while (proc_u.n_rs < FIFO_DEPTH && c < 4000) begin
        tick(1);
        c++;
      end
      if (c >= 4000) n_mismatch++;
      tick(100);
      check(16'(proc_u.n_rs), 16'(FIFO_DEPTH));
      rx_ready = 1'b1;
    end
    tick(2);
    c = 0;
    while (svc_busy !== 1'b0 && c < 8000) begin
      tick(1);
      c++;
    end
    if (c >= 8000) n_mismatch++;
    tick(3);
    check(16'(proc_u.fr_q), 16'(my_addr));
    check(16'(proc_u.kind_q), 16'(k));
    check(16'(term_got), 16'(TERM_V));
    case (k)
      SVC_DATA_OUT: begin
        check(16'(rx_got.size()), 16'(n));
        for (int i = 0; i < n && i < rx_got.size(); i++) check(16'(rx_got[i]), 16'h40 + 16'(i));
        check(16'(rx_valid), 16'h0000);
      end
      SVC_DATA_IN: begin
        check(16'(proc_u.rx_q.size()), 16'(n));
        for (int i = 0; i < n && i < proc_u.rx_q.size(); i++) check(16'(proc_u.rx_q[i]), 16'h80 + 16'(i));
      end
      SVC_ORDER_OUT: check(16'(ord_got), 16'h0040);
      default: check(16'(proc_u.rx_q.size() > 0 ? proc_u.rx_q[0] : 8'h00), 16'(op_status));
    endcase
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    svc_req = 1'b0;
    svc_kind = SVC_DATA_IN;
    my_addr = 8'h3C;
    dev_status = 8'h5A;
    cond_code = 2'h2;
    irq_pending = 1'b0;
    op_status = 8'h1D;
    rx_ready = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(3);
    t_cpu_ops();
    t_aio();
    t_svc(SVC_DATA_OUT, 17, 1'b1);
    t_svc(SVC_DATA_IN, 3, 1'b0);
    t_svc(SVC_ORDER_OUT, 1, 1'b0);
    t_svc(SVC_ORDER_IN, 1, 1'b0);
    tally_and_finish();
  end

  initial begin
    #1_500_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
